// [src/serial_ctrl3_consts.vh]
// constants for the third serial port control register block
`ifndef SERIAL_CTRL3_CONSTS_VH
`define SERIAL_CTRL3_CONSTS_VH
// register byte offsets
`define OFS_CTRL3 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_LINE_STATUS 8'h0C
`define OFS_AUTOBAUD_COUNT 8'h10
`define OFS_BAUD_MOD 8'h14
`define OFS_PRESET_0 8'h18
`define OFS_PRESET_1 8'h1C
// control three field positions
`define BIT_PARITY_ERR_EN 12
`define BIT_FRAME_ERR_EN 11
`define BIT_RX_STATUS_EN 6
`define BIT_IR_WAKE_EN 5
`define BIT_RX_WAKE_EN 4
`define BIT_REF_25 3
`define BIT_REF_30 2
`define BIT_IR_INVERT 1
`define BIT_BAUD_PRESET 0
// writable bits of control three, reserved bits 10..7 and above 12 stay zero
`define CTRL3_WMASK 32'h0000187F
`define CTRL3_RESET 32'h00000000
// status bit positions
`define ST_PFERR 0
`define ST_RX 1
`define ST_IR_WAKE 2
`define ST_RX_WAKE 3
`define ST_WIDTH 4
`define ST_RESET 4'h0
`define MASK_RESET 4'h0
// infrared pulse: 3/16 of a bit, in oversample ticks
`define IR_PULSE_TICKS 5'h03
`define IR_BIT_TICKS 5'h10
// preset baud selection criteria
`define PRESET_0_DIVIDEND 16'h0001
`define PRESET_0_REMAINDER 4'h8
`define PRESET_1_DIVIDEND 16'h0003
`define PRESET_1_REMAINDER 4'h4
`define PRESET_RESET 16'h0000
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [src/rx_edge_detect.v]
// synchroniser and edge finder for the receive pin
`timescale 1ns/1ps
`default_nettype none
module rx_edge_detect (
   input wire aclk,
   input wire aresetn,
   input wire pin_in,
   output reg level,
   output reg fall,
   output reg pulse
);
   reg sync1_reg; // first stage, read only by second
   reg sync2_reg; // second stage
   reg prev_reg; // delayed copy for edges

   // two-flop synchroniser then edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         prev_reg <= 1'b1;
         level <= 1'b1;
         fall <= 1'b0;
         pulse <= 1'b0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
         level <= sync2_reg;
         fall <= prev_reg & ~sync2_reg; // high to low
         pulse <= prev_reg ^ sync2_reg; // any pulse edge
      end
   end
endmodule // rx_edge_detect
`default_nettype wire

// [src/ir_tx_encoder.v]
// infrared encoder: 3/16 bit pulse for each zero
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl3_consts.vh"
module ir_tx_encoder (
   input wire aclk,
   input wire aresetn,
   input wire tick16,
   input wire tx_bit,
   input wire invert,
   output reg ir_out
);
   reg [4:0] phase_reg; // position within the bit
   reg pulse_now; // pulse active this tick

   // count ticks in the bit and shape the pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= 5'h00;
         ir_out <= 1'b0;
      end else begin
         if (tick16) begin
            if (phase_reg == `IR_BIT_TICKS - 5'h01)
               phase_reg <= 5'h00;
            else
               phase_reg <= phase_reg + 5'h01;
         end
         ir_out <= invert ^ pulse_now; // (R8) (R9)
      end
   end

   // pulse only while a zero is sent and early in the bit
   always @* begin
      pulse_now = ~tx_bit & (phase_reg < `IR_PULSE_TICKS);
   end
endmodule // ir_tx_encoder
`default_nettype wire

// [src/serial_ctrl3.v]
// third control register of the serial port with its interrupts
//
// Overview of operation
// (R1) parity error raises combined error interrupt when enabled
// (R2) frame error raises combined error interrupt when enabled
// (R3) receive status raises receive interrupt when enabled
// (R4) receive pin pulse raises infrared wake interrupt
// (R5) receive pin falling edge raises wake interrupt
// (R6) bit three marks 25 MHz reference clock
// (R7) bit two marks 30 MHz reference clock
// (R8) not inverted: positive 3/16 pulse per zero
// (R9) inverted: negative 3/16 pulse per zero
// (R10) preset off: ignore auto baud remainder
// (R11) preset on: remainder and dividend pick preset
// (R12) no preset match: load dividend minus one
// (R13) reserved bits 10 to 7 read zero
// (R14) interrupt stands only while cause and enable
//
// register map, byte offsets on the register bus:
// 0x00 control three, bits 12, 11 and 6 to 0 writable
// 0x04 sticky event status, write one to clear
// 0x08 interrupt mask, same layout as status
// 0x0C line status: synced flags, cause levels, line level
// 0x10 last automatic baud count
// 0x14 baud modulator value, read only
// 0x18 first preset modulator value
// 0x1C second preset modulator value
// status bits: 0 parity or frame, 1 receive, 2 infrared wake, 3 receive wake
// unmapped offsets and writes to read-only ones get an error response
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl3_consts.vh"
module serial_ctrl3 (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire parity_err_flag,
   input wire frame_err_flag,
   input wire rx_status_flag,
   input wire rx_pin,
   input wire tx_bit,
   input wire tick16,
   input wire autobaud_done,
   input wire [19:0] autobaud_count,
   output reg parity_frame_err_irq,
   output reg rx_irq,
   output reg ir_wake_irq,
   output reg rx_wake_irq,
   output reg irq,
   output reg ir_tx,
   output reg ref_is_25mhz,
   output reg ref_is_30mhz,
   output reg [15:0] baud_modulator_reg,
   output reg baud_mod_load
);
   reg [31:0] ctrl3_reg; // control three contents
   reg [`ST_WIDTH-1:0] status_reg; // sticky event bits
   reg [`ST_WIDTH-1:0] mask_reg; // interrupt enables for status
   reg [15:0] preset0_reg; // first preset modulator value
   reg [15:0] preset1_reg; // second preset modulator value
   reg [19:0] count_reg; // last auto baud count
   reg pf_sync1_reg; // parity flag sync first stage
   reg pf_sync2_reg; // parity flag synced
   reg fe_sync1_reg; // frame flag sync first stage
   reg fe_sync2_reg; // frame flag synced
   reg rs_sync1_reg; // receive status sync first stage
   reg rs_sync2_reg; // receive status synced
   reg [`ST_WIDTH-1:0] cause_prev_reg; // previous cause levels
   // bus capture state, held until the response is accepted
   reg aw_held_reg; // write address captured
   reg [7:0] aw_addr_reg; // captured write address
   reg w_held_reg; // write data captured
   reg [31:0] w_data_reg; // captured write data
   reg [3:0] w_strb_reg; // captured strobes
   // combinational helpers
   reg [`ST_WIDTH-1:0] cause; // live interrupt causes
   reg [`ST_WIDTH-1:0] rise; // new event this cycle
   reg [`ST_WIDTH-1:0] clr; // write one to clear
   wire [31:0] wmerged; // write data merged by strobes
   reg [31:0] rd_value; // read mux
   reg rd_ok; // read address mapped
   reg wr_ok; // write address mapped
   reg do_write; // write commits this cycle
   // submodule outputs
   wire rx_level; // synced receive pin
   wire rx_fall; // falling edge on receive pin
   wire rx_pulse; // any edge on receive pin
   wire ir_out; // encoder output
   wire [15:0] dividend; // auto baud count over 16
   wire [3:0] remainder; // auto baud count mod 16
   genvar g; // byte lane index

   // receive pin synchroniser and edge detector
   // the pin is asynchronous: only the second sync stage feeds logic,
   // so a wake edge is never taken from a metastable sample
   rx_edge_detect rx_edge_detect_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(rx_pin),
      .level(rx_level),
      .fall(rx_fall),
      .pulse(rx_pulse)
   );

   // infrared transmit shaping
   // polarity follows the control bit at once; the pulse phase runs free
   // on the oversample tick, so the first pulse after a change may be short
   ir_tx_encoder ir_tx_encoder_inst (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick16(tick16),
      .tx_bit(tx_bit),
      .invert(ctrl3_reg[`BIT_IR_INVERT]),
      .ir_out(ir_out)
   );

   assign dividend = autobaud_count[19:4];
   assign remainder = autobaud_count[3:0];

   // interrupt causes gated by control three enables
   // causes are levels; status keeps only their rising edge,
   // so a cause that stays high sets its status bit once
   always @* begin
      cause[`ST_PFERR] = (pf_sync2_reg & ctrl3_reg[`BIT_PARITY_ERR_EN]) | // (R1)
         (fe_sync2_reg & ctrl3_reg[`BIT_FRAME_ERR_EN]); // (R2)
      cause[`ST_RX] = rs_sync2_reg & ctrl3_reg[`BIT_RX_STATUS_EN]; // (R3)
      cause[`ST_IR_WAKE] = rx_pulse & ctrl3_reg[`BIT_IR_WAKE_EN]; // (R4)
      cause[`ST_RX_WAKE] = rx_fall & ctrl3_reg[`BIT_RX_WAKE_EN]; // (R5)
      rise = cause & ~cause_prev_reg;
   end

   // address decode and write merge
   // a write commits once both halves are held and no response is
   // pending, so one request can never update a register twice
   always @* begin
      wr_ok = (aw_addr_reg == `OFS_CTRL3) || (aw_addr_reg == `OFS_IRQ_STATUS) ||
         (aw_addr_reg == `OFS_IRQ_MASK) || (aw_addr_reg == `OFS_PRESET_0) ||
         (aw_addr_reg == `OFS_PRESET_1);
      do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
      clr = (do_write && aw_addr_reg == `OFS_IRQ_STATUS) ? wmerged[`ST_WIDTH-1:0] : `ST_RESET;
   end

   // byte lanes of the write data: a lane without its strobe writes zero
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign wmerged[g*8 +: 8] = w_strb_reg[g] ? w_data_reg[g*8 +: 8] : 8'h00;
      end
   endgenerate

   // read mux
   // decoded straight from the read address; unmapped offsets read
   // zero and get an error response from the read channel
   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `OFS_CTRL3: rd_value = ctrl3_reg & `CTRL3_WMASK; // (R13)
         `OFS_IRQ_STATUS: rd_value = {28'h0000000, status_reg};
         `OFS_IRQ_MASK: rd_value = {28'h0000000, mask_reg};
         `OFS_LINE_STATUS: rd_value = {25'h0000000, rx_level, cause_prev_reg, fe_sync2_reg, pf_sync2_reg};
         `OFS_AUTOBAUD_COUNT: rd_value = {12'h000, count_reg};
         `OFS_BAUD_MOD: rd_value = {16'h0000, baud_modulator_reg};
         `OFS_PRESET_0: rd_value = {16'h0000, preset0_reg};
         `OFS_PRESET_1: rd_value = {16'h0000, preset1_reg};
         default: begin
            rd_value = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // axi write channels: address and data in either order
   // ready pulses the cycle after capture, while valid still stands;
   // no new address or data is taken until the response is accepted
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
         end
      end
   end

   // axi read channel
   // ready, valid and data rise together one cycle after the request;
   // the next request waits until rready has taken the data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // software registers
   // reserved control bits are masked on write as well as on read,
   // so they read zero whatever software writes
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl3_reg <= `CTRL3_RESET;
         mask_reg <= `MASK_RESET;
         preset0_reg <= `PRESET_RESET;
         preset1_reg <= `PRESET_RESET;
      end else if (do_write) begin
         case (aw_addr_reg)
            `OFS_CTRL3: ctrl3_reg <= (ctrl3_reg & ~`CTRL3_WMASK) | (wmerged & `CTRL3_WMASK); // (R13)
            `OFS_IRQ_MASK: mask_reg <= wmerged[`ST_WIDTH-1:0];
            `OFS_PRESET_0: preset0_reg <= wmerged[15:0];
            `OFS_PRESET_1: preset1_reg <= wmerged[15:0];
            default: begin
            end
         endcase
      end
   end

   // flag synchronisers and sticky status, set wins over clear
   // each flag passes two flops before any logic reads it;
   // an event and a clear in one cycle leave the bit set
   always @(posedge aclk) begin
      if (!aresetn) begin
         pf_sync1_reg <= 1'b0;
         pf_sync2_reg <= 1'b0;
         fe_sync1_reg <= 1'b0;
         fe_sync2_reg <= 1'b0;
         rs_sync1_reg <= 1'b0;
         rs_sync2_reg <= 1'b0;
         cause_prev_reg <= `ST_RESET;
         status_reg <= `ST_RESET;
      end else begin
         pf_sync1_reg <= parity_err_flag;
         pf_sync2_reg <= pf_sync1_reg;
         fe_sync1_reg <= frame_err_flag;
         fe_sync2_reg <= fe_sync1_reg;
         rs_sync1_reg <= rx_status_flag;
         rs_sync2_reg <= rs_sync1_reg;
         cause_prev_reg <= cause;
         status_reg <= (status_reg & ~clr) | rise;
      end
   end

   // interrupt outputs and indications
   // every output is registered, one cycle behind its source; irq lags cause by two;
   // the combined line is high while any unmasked status bit is set
   always @(posedge aclk) begin
      if (!aresetn) begin
         parity_frame_err_irq <= 1'b0;
         rx_irq <= 1'b0;
         ir_wake_irq <= 1'b0;
         rx_wake_irq <= 1'b0;
         irq <= 1'b0;
         ir_tx <= 1'b0;
         ref_is_25mhz <= 1'b0;
         ref_is_30mhz <= 1'b0;
      end else begin
         parity_frame_err_irq <= cause[`ST_PFERR]; // (R14)
         rx_irq <= cause[`ST_RX]; // (R14)
         ir_wake_irq <= cause[`ST_IR_WAKE];
         rx_wake_irq <= cause[`ST_RX_WAKE];
         irq <= |(status_reg & mask_reg);
         ir_tx <= ir_out;
         ref_is_25mhz <= ctrl3_reg[`BIT_REF_25]; // (R6)
         ref_is_30mhz <= ctrl3_reg[`BIT_REF_30]; // (R7)
      end
   end

   // automatic baud result: preset selection or integer division
   // a preset needs the enable and an exact dividend and remainder;
   // otherwise the modulator takes the dividend minus one
   always @(posedge aclk) begin
      if (!aresetn) begin
         baud_modulator_reg <= 16'h0000;
         baud_mod_load <= 1'b0;
         count_reg <= 20'h00000;
      end else begin
         baud_mod_load <= autobaud_done;
         if (autobaud_done) begin
            count_reg <= autobaud_count;
            if (ctrl3_reg[`BIT_BAUD_PRESET] && dividend == `PRESET_0_DIVIDEND &&
               remainder == `PRESET_0_REMAINDER)
               baud_modulator_reg <= preset0_reg; // (R11)
            else if (ctrl3_reg[`BIT_BAUD_PRESET] && dividend == `PRESET_1_DIVIDEND &&
               remainder == `PRESET_1_REMAINDER)
               baud_modulator_reg <= preset1_reg; // (R11)
            else
               baud_modulator_reg <= dividend - 16'h0001; // (R10) (R12)
         end
      end
   end
endmodule // serial_ctrl3
`default_nettype wire

// [verification/serial_ctrl3_assertions.sv]
// checker for the control three block ports
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl3_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic parity_err_flag,
   input wire logic frame_err_flag,
   input wire logic rx_status_flag,
   input wire logic rx_pin,
   input wire logic autobaud_done,
   input wire logic parity_frame_err_irq,
   input wire logic rx_irq,
   input wire logic ir_wake_irq,
   input wire logic rx_wake_irq,
   input wire logic baud_mod_load,
   input wire logic [15:0] baud_modulator_reg
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // no error cause for four cycles: combined output low
   property p_pferr_off; (!parity_err_flag && !frame_err_flag) [*4] |=> !parity_frame_err_irq; endproperty
   a_pferr_off: assert property (p_pferr_off) else $error("error irq without cause");
   // receive status gone: receive output low
   property p_rx_off; (!rx_status_flag) [*4] |=> !rx_irq; endproperty
   a_rx_off: assert property (p_rx_off) else $error("rx irq without cause");
   // no falling edge on the line: no wake pulse
   property p_rx_wake_quiet; rx_pin [*8] |=> !rx_wake_irq; endproperty
   a_rx_wake_quiet: assert property (p_rx_wake_quiet) else $error("wake irq on idle line");
   // no line pulse: no infrared wake pulse
   property p_ir_wake_quiet; $stable(rx_pin) [*8] |=> !ir_wake_irq; endproperty
   a_ir_wake_quiet: assert property (p_ir_wake_quiet) else $error("ir wake irq on still line");
   // auto baud result loads one cycle later
   property p_load; autobaud_done |=> baud_mod_load; endproperty
   a_load: assert property (p_load) else $error("baud modulator not loaded");
   // modulator only changes on a load
   property p_mod_hold; !baud_mod_load |-> $stable(baud_modulator_reg); endproperty
   a_mod_hold: assert property (p_mod_hold) else $error("baud modulator changed without load");
   // one write response per handshake
   property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_drop: assert property (p_b_drop) else $error("write response repeated");
   // one read response per handshake
   property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_drop: assert property (p_r_drop) else $error("read response repeated");
   // main scenarios reached
   c_pferr: cover property (parity_frame_err_irq);
   c_wake: cover property (rx_wake_irq);
   c_load: cover property (baud_mod_load);
endmodule // serial_ctrl3_chk
bind serial_ctrl3 serial_ctrl3_chk serial_ctrl3_chk_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .parity_err_flag(parity_err_flag), .frame_err_flag(frame_err_flag),
   .rx_status_flag(rx_status_flag), .rx_pin(rx_pin), .autobaud_done(autobaud_done),
   .parity_frame_err_irq(parity_frame_err_irq), .rx_irq(rx_irq), .ir_wake_irq(ir_wake_irq),
   .rx_wake_irq(rx_wake_irq), .baud_mod_load(baud_mod_load), .baud_modulator_reg(baud_modulator_reg));
`default_nettype wire

// [verification/serial_line_model.sv]
// far side model: oversample ticks and receive line pulses
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
   input wire logic aclk,
   input wire logic send_pulse,
   output wire logic tick16,
   output wire logic rx_pin
);
   logic [1:0] div = 2'h0; // tick divider, one tick in four
   logic [2:0] low_cnt = 3'h0; // low cycles left
   // tick divider and line pulse timer
   always @(posedge aclk) begin
      div <= div + 2'h1;
      if (send_pulse) low_cnt <= 3'h6;
      else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
   end
   assign tick16 = (div == 2'h3);
   assign rx_pin = (low_cnt == 3'h0); // line idles high
endmodule // serial_line_model
`default_nettype wire

// [verification/serial_ctrl3_tb.sv]
// self-checking bench for the control three block
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl3_consts.vh"
module serial_ctrl3_tb;
   logic aclk = 1'b0, aresetn = 1'b0; // clock and reset
   logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [1:0] last_b = 2'h0; // response of the last write
   logic [31:0] rdata;
   logic pe = 1'b0, fe = 1'b0, rs = 1'b0, tx_bit = 1'b0, ab_done = 1'b0, send_pulse = 1'b0;
   logic [19:0] ab_cnt = 20'h00000; // dividend and remainder
   logic pfi, rxi, iwi, rwi, irq, ir_tx, r25, r30, bml, rx_pin, tick16;
   logic [15:0] bmr;
   int err_total = 0, n_checks = 0, cyc = 0, n_ir = 0, n_rx = 0, n_hi = 0;
   serial_ctrl3 serial_ctrl3_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .parity_err_flag(pe), .frame_err_flag(fe), .rx_status_flag(rs), .rx_pin(rx_pin), .tx_bit(tx_bit),
      .tick16(tick16), .autobaud_done(ab_done), .autobaud_count(ab_cnt), .parity_frame_err_irq(pfi),
      .rx_irq(rxi), .ir_wake_irq(iwi), .rx_wake_irq(rwi), .irq(irq), .ir_tx(ir_tx), .ref_is_25mhz(r25),
      .ref_is_30mhz(r30), .baud_modulator_reg(bmr), .baud_mod_load(bml));
   serial_line_model serial_line_model_inst (.aclk(aclk), .send_pulse(send_pulse), .tick16(tick16),
      .rx_pin(rx_pin));
   // 50 ns clock
   initial forever #25 aclk = ~aclk;
   // pulse and level counters, sampled away from the launch edge
   always @(negedge aclk) begin
      if (iwi) n_ir++;
      if (rwi) n_rx++;
      if (ir_tx) n_hi++;
   end
   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // compare and report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
         begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
      join
      while (bvalid !== 1'b1) @(posedge aclk);
      last_b = bresp;
      bready <= 1'b0;
   endtask
   // bus read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      arvalid <= 1'b0;
      rready <= 1'b0;
   endtask
   int en_b[3] = '{12, 11, 6}; // enable bit per cause
   int ir_exp[4] = '{24, 0, 104, 128}; // high cycles in two bit periods
   logic pen[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1}; // preset enable per case
   logic [15:0] dv[5] = '{16'h0005, 16'h0003, 16'h0001, 16'h0003, 16'h0003};
   logic [3:0] rm[5] = '{4'h3, 4'h4, 4'h8, 4'h4, 4'h5};
   logic [15:0] ex[5] = '{16'h0004, 16'h0002, 16'h1234, 16'h5678, 16'h0002};
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      cw(10);
      aresetn <= 1'b1;
      rd(`OFS_CTRL3, d, r); chk("ctrl3 reset", d, 32'h00000000);
      wr(`OFS_CTRL3, 32'h0000187F); rd(`OFS_CTRL3, d, r); chk("ctrl3 bits", d, 32'h0000187F);
      chk("write resp", last_b, 2'h0);
      wr(`OFS_BAUD_MOD, 32'h00000001); chk("read-only write resp", last_b, 2'h2);
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_CTRL3, i << 2); cw(3); chk("ref flags", {r25, r30}, i[1:0]);
      end
      rd(8'h40, d, r); chk("unmapped resp", r, 2'h2); chk("unmapped data", d, 32'h00000000);
      for (int i = 0; i < 3; i++) begin
         wr(`OFS_CTRL3, 32'h00000000); wr(`OFS_IRQ_MASK, 32'h0000000F);
         {rs, fe, pe} <= 3'b001 << i;
         cw(8); chk("irq disabled", {rxi, pfi}, 2'b00); chk("no irq", irq, 1'b0);
         wr(`OFS_CTRL3, 32'h00000001 << en_b[i]); cw(8);
         chk("irq enabled", {rxi, pfi}, (i == 2) ? 2'b10 : 2'b01);
         rd(`OFS_IRQ_STATUS, d, r); chk("status set", d, (i == 2) ? 32'h2 : 32'h1);
         {rs, fe, pe} <= 3'b000;
         cw(8); chk("irq follows cause", {rxi, pfi}, 2'b00); chk("sticky irq", irq, 1'b1);
         wr(`OFS_IRQ_MASK, 32'h00000000); cw(3); chk("masked irq", irq, 1'b0);
         wr(`OFS_IRQ_MASK, 32'h0000000F); cw(3); chk("unmasked irq", irq, 1'b1);
         wr(`OFS_IRQ_STATUS, 32'h0000000F); cw(3); chk("cleared irq", irq, 1'b0);
      end
      for (int e = 0; e < 2; e++) begin
         wr(`OFS_CTRL3, e ? 32'h00000030 : 32'h00000000);
         n_ir = 0;
         n_rx = 0;
         send_pulse <= 1'b1; cw(1); send_pulse <= 1'b0; cw(20);
         chk("ir wake pulses", n_ir, e ? 2 : 0);
         chk("rx wake pulses", n_rx, e ? 1 : 0);
      end
      for (int k = 0; k < 4; k++) begin
         wr(`OFS_CTRL3, k[1] ? 32'h00000002 : 32'h00000000);
         tx_bit <= k[0]; cw(130); n_hi = 0; cw(128);
         chk("ir high cycles", n_hi, ir_exp[k]);
      end
      wr(`OFS_PRESET_0, 32'h00001234); wr(`OFS_PRESET_1, 32'h00005678);
      for (int j = 0; j < 5; j++) begin
         wr(`OFS_CTRL3, {31'h0, pen[j]});
         @(posedge aclk); ab_cnt <= {dv[j], rm[j]}; ab_done <= 1'b1;
         @(posedge aclk); ab_done <= 1'b0;
         while (bml !== 1'b1) @(posedge aclk);
         chk("baud modulator", bmr, ex[j]);
      end
      give_verdict();
   end
endmodule // serial_ctrl3_tb
`default_nettype wire
